// *** dv/samu_core_asserts.sv ***
// Checks on the short absolute move unit ports
`timescale 1ns/10ps
module samu_core_asserts (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                start,
  input wire samu_pkg::samu_cmd_t cmd,
  input wire logic                busy,
  input wire logic                done,
  input wire logic                illegal,
  input wire samu_pkg::samu_wb_t  wb,
  input wire logic [15:0]         mem_addr,
  input wire logic                mem_rd,
  input wire logic                mem_wr,
  input wire logic [15:0]         mem_wdata,
  input wire logic [15:0]         ccr_in,
  input wire logic                ccr_clr_limit,
  input wire logic [15:0]         ccr_out
);
  import samu_pkg::*;
  logic tk;
  assign tk = start && !busy && !illegal;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RANGE: assert property ((mem_rd || mem_wr) |-> mem_addr[15:6] == 10'h000)
    else $error("address out of range");
  AST_LOAD: assert property (tk && cmd.form == SAMU_LOAD |=> mem_rd ##1 done && wb.we)
    else $error("load timing");
  AST_STORE: assert property (tk && cmd.form == SAMU_STORE |=> mem_wr ##1 done)
    else $error("store timing");
  AST_IMM: assert property (tk && cmd.form == SAMU_STORE_IMM |=> !done[*2] ##1 mem_wr ##1 done)
    else $error("immediate timing");
  AST_IMMD: assert property (tk && cmd.form == SAMU_STORE_IMM |-> ##3 mem_wdata == $past(cmd.imm, 3))
    else $error("immediate data");
  AST_EXT: assert property (wb.we |-> wb.acc_val == {{4{wb.word_val[15]}}, wb.word_val, 16'h0000})
    else $error("accumulator extension");
  AST_STICKY: assert property (ccr_out[6] && !ccr_in[6] && !ccr_clr_limit |=> ccr_out[6])
    else $error("limit flag lost");
  AST_KEEP: assert property ({ccr_out[15:8], ccr_out[5:0]} == {ccr_in[15:8], ccr_in[5:0]})
    else $error("other flags changed");
endmodule
bind samu_core samu_core_asserts samu_core_asserts_i (.clk(clk), .rst(rst), .start(start),
  .cmd(cmd), .busy(busy), .done(done), .illegal(illegal), .wb(wb), .mem_addr(mem_addr),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .ccr_in(ccr_in),
  .ccr_clr_limit(ccr_clr_limit), .ccr_out(ccr_out));

// *** dv/samu_core_tb.sv ***
// Self-checking bench for the short absolute move unit
`timescale 1ns/10ps
module samu_core_tb;
  import samu_pkg::*;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, clr = 1'b0, busy, done, illegal, rd, wr;
  samu_cmd_t cmd = '0;
  samu_wb_t wb;
  logic [35:0] acc = '0;
  logic [15:0] rw = '0, condition_code_register = '0, rdata, addr, wd, ccro;
  logic [31:0] qm[$], qw[$], s = 32'h6F80, w;
  logic lf = 1'b0, sz = 1'b0;
  int error_cnt = 0, n_checks = 0;
  always #2.5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  samu_core samu_core_i (.clk(clk), .rst(rst), .start(start), .cmd(cmd), .busy(busy),
    .done(done), .illegal(illegal), .acc_a(acc), .acc_b(acc), .reg_word(rw), .reg_rd_sel(),
    .wb(wb), .mem_addr(addr), .mem_rd(rd), .mem_wr(wr), .mem_wdata(wd), .mem_rdata(rdata),
    .ccr_in(condition_code_register), .ccr_clr_limit(clr), .ccr_out(ccro));
  samu_mem_model samu_mem_model_i (.clk(clk), .mem_addr(addr), .mem_rd(rd), .mem_wr(wr),
    .mem_wdata(wd), .mem_rdata(rdata));
  task automatic chk(input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic mv(samu_form_t f, samu_reg_t r, logic [5:0] a, logic [15:0] d, logic [35:0] ac);
    int n;
    @(posedge clk);
    start <= 1'b1;
    cmd <= '{f, r, a, d};
    rw <= d;
    acc <= ac;
    condition_code_register <= s[31:16] & 16'hFF3F;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 8; n++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    if (n == 8) begin
      error_cnt++;
      summarize();
    end
  endtask
  // Results are compared in order as they appear
  always @(negedge clk) begin
    if (wr === 1'b1) chk(qm.pop_front(), {addr, wd});
    if (wb.we === 1'b1) begin
      w = qw.pop_front();
      chk({16'h0000, w[15:0]}, {16'h0000, wb.word_val});
      chk({28'h0000000, w[19:16]}, {28'h0000000, wb.reg_sel});
      chk({w[15:0], 16'h0000}, wb.acc_val[31:0]);
      chk({28'h0000000, {4{w[15]}}}, {28'h0000000, wb.acc_val[35:32]});
    end
  end
  initial begin
    logic [15:0] d, e;
    logic [35:0] ac;
    logic sat;
    samu_reg_t r, rl;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 28; i++) begin
      s = lfsr(s);
      d = s[15:0];
      r = samu_reg_t'(i % 14);
      ac = {i % 3 == 0 ? {4{d[15]}} : (i % 3 == 1 ? 4'h5 : 4'hA), d, d};
      sat = (r == SAMU_R_A || r == SAMU_R_B) && ac[35:31] != {5{ac[35]}};
      e = !sat ? d : (ac[35] ? 16'h8000 : 16'h7FFF);
      lf |= sat;
      sz |= d[14] ^ d[13];
      qm.push_back({10'h000, s[21:16], e});
      mv(SAMU_STORE, r, s[21:16], d, ac);
      rl = (r > SAMU_R_N) ? SAMU_R_X0 : r;
      qw.push_back({12'h000, rl, e});
      mv(SAMU_LOAD, rl, s[21:16], 16'h0000, 36'h0);
      chk({30'h0, sz, lf}, {30'h0, ccro[7:6]});
      if (i % 5 == 4) begin
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        lf = 1'b0;
      end
    end
    qm.push_back({16'h0024, 16'h0342});
    mv(SAMU_STORE_IMM, SAMU_R_X0, 6'h24, 16'h0342, 36'h0);
    @(posedge clk);
    start <= 1'b1;
    cmd <= '{SAMU_LOAD, SAMU_R_A0, 6'h01, 16'h0000};
    #1 chk(32'h1, {31'h0, illegal});
    @(posedge clk) start <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'h0, qm.size() + qw.size());
    summarize();
  end
endmodule

// *** dv/samu_mem_model.sv ***
// Data memory model for the lowest 64 words
`timescale 1ns/10ps
module samu_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_wdata,
  output logic      [15:0] mem_rdata
);
  logic [15:0] m [64];
  logic [15:0] last = 16'h0000;
  // Idle bus shows the inverse of the last word read
  assign mem_rdata = mem_rd ? m[mem_addr[5:0]] : ~last;
  always @(posedge clk) begin
    if (mem_wr) m[mem_addr[5:0]] <= mem_wdata;
    if (mem_rd) last <= m[mem_addr[5:0]];
  end
endmodule

// *** hw/samu_core.sv ***
// Short absolute move execution datapath
`timescale 1ns/10ps
`include "samu_cfg.svh"
module samu_core (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               start,
  input  wire samu_pkg::samu_cmd_t cmd,
  output logic                    busy,
  output logic                    done,
  output logic                    illegal,
  input  wire logic [35:0]        acc_a,
  input  wire logic [35:0]        acc_b,
  input  wire logic [15:0]        reg_word,
  output samu_pkg::samu_reg_t     reg_rd_sel,
  output samu_pkg::samu_wb_t      wb,
  output logic [15:0]             mem_addr,
  output logic                    mem_rd,
  output logic                    mem_wr,
  output logic [15:0]             mem_wdata,
  input  wire logic [15:0]        mem_rdata,
  input  wire logic [15:0]        ccr_in,
  input  wire logic               ccr_clr_limit,
  output logic [15:0]             ccr_out
);
  import samu_pkg::*;

  typedef enum logic [1:0] {
    SAMU_IDLE,
    SAMU_RUN
  } samu_st_t;

  samu_st_t    st_q, st_d;
  samu_cmd_t   cmd_q, cmd_d;
  logic [2:0]  cnt_q, cnt_d;
  logic [15:0] addr_q, addr_d;
  logic        rd_q, rd_d, wr_q, wr_d, done_q, done_d;
  logic [15:0] wdata_q, wdata_d;
  samu_wb_t    wb_q, wb_d;
  logic        l_q, l_d, sz_q, sz_d;
  logic        legal, full_src, lim, szh;
  logic [35:0] acc_src;
  logic [15:0] sat_word;

  always_comb begin
    legal = 1'b1;
    if (cmd.form == SAMU_LOAD) begin
      legal = (cmd.reg_sel <= SAMU_R_N);
    end else if (cmd.form == SAMU_STORE) begin
      legal = (cmd.reg_sel <= SAMU_R_B0);
    end else if (cmd.form != SAMU_STORE_IMM) begin
      legal = 1'b0;
    end
    full_src = (cmd.form == SAMU_STORE) &&
               ((cmd.reg_sel == SAMU_R_A) || (cmd.reg_sel == SAMU_R_B));
    acc_src = (cmd.reg_sel == SAMU_R_B) ? acc_b : acc_a;
  end

  assign reg_rd_sel = cmd.reg_sel;

  samu_sat u_sat (
    .acc_in   (acc_src),
    .full_acc (full_src),
    .word_in  (reg_word),
    .word_out (sat_word),
    .limited  (lim),
    .size_hit (szh)
  );

  always_comb begin
    st_d    = st_q;
    cmd_d   = cmd_q;
    cnt_d   = cnt_q;
    addr_d  = addr_q;
    rd_d    = 1'b0;
    wr_d    = 1'b0;
    done_d  = 1'b0;
    wdata_d = wdata_q;
    wb_d    = wb_q;
    wb_d.we = 1'b0;
    l_d     = l_q;
    sz_d    = sz_q;
    if (ccr_clr_limit) begin
      l_d = 1'b0;
    end
    case (st_q)
      SAMU_IDLE: begin
        if (start && legal) begin
          cmd_d  = cmd;
          addr_d = {10'h000, cmd.short_address_field};
          st_d   = SAMU_RUN;
          case (cmd.form)
            SAMU_LOAD: begin
              rd_d  = 1'b1;
              cnt_d = 3'(`SAMU_CYC_REG - 1);
            end
            SAMU_STORE: begin
              wr_d    = 1'b1;
              wdata_d = sat_word;
              if (lim) begin
                l_d = 1'b1;
              end
              if (szh) begin
                sz_d = 1'b1;
              end
              cnt_d = 3'(`SAMU_CYC_REG - 1);
            end
            default: begin
              cnt_d = 3'(`SAMU_CYC_IMM - 1);
            end
          endcase
        end
      end
      SAMU_RUN: begin
        cnt_d = cnt_q - 3'h1;
        if (cmd_q.form == SAMU_STORE_IMM && cnt_q == 3'h2) begin
          wr_d    = 1'b1;
          wdata_d = cmd_q.imm;
          if (cmd_q.imm[14] != cmd_q.imm[13]) begin
            sz_d = 1'b1;
          end
        end
        if (cmd_q.form == SAMU_LOAD && cnt_q == 3'h1) begin
          wb_d.we       = 1'b1;
          wb_d.reg_sel  = cmd_q.reg_sel;
          wb_d.word_val = mem_rdata;
          wb_d.acc_val  = {{4{mem_rdata[15]}}, mem_rdata, 16'h0000};
          if (mem_rdata[14] != mem_rdata[13]) begin
            sz_d = 1'b1;
          end
        end
        if (cnt_q == 3'h1) begin
          done_d = 1'b1;
          st_d   = SAMU_IDLE;
        end
      end
      default: st_d = SAMU_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q    <= SAMU_IDLE;
      cmd_q   <= '0;
      cnt_q   <= 3'h0;
      addr_q  <= 16'h0000;
      rd_q    <= 1'b0;
      wr_q    <= 1'b0;
      done_q  <= 1'b0;
      wdata_q <= 16'h0000;
      wb_q    <= '0;
      l_q     <= 1'b0;
      sz_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      cmd_q   <= cmd_d;
      cnt_q   <= cnt_d;
      addr_q  <= addr_d;
      rd_q    <= rd_d;
      wr_q    <= wr_d;
      done_q  <= done_d;
      wdata_q <= wdata_d;
      wb_q    <= wb_d;
      l_q     <= l_d;
      sz_q    <= sz_d;
    end
  end

  always_comb begin
    ccr_out = ccr_in;
    ccr_out[`SAMU_CCR_L_BIT]  = ccr_in[`SAMU_CCR_L_BIT] | l_q;
    ccr_out[`SAMU_CCR_SZ_BIT] = ccr_in[`SAMU_CCR_SZ_BIT] | sz_q;
  end

  assign busy      = (st_q != SAMU_IDLE);
  assign done      = done_q;
  assign illegal   = start && !busy && !legal;
  assign mem_addr  = addr_q;
  assign mem_rd    = rd_q;
  assign mem_wr    = wr_q;
  assign mem_wdata = wdata_q;
  assign wb        = wb_q;
endmodule

// *** hw/samu_sat.sv ***
// Accumulator limiter and size flag evaluation
`timescale 1ns/10ps
`include "samu_cfg.svh"
module samu_sat (
  input  wire logic [35:0] acc_in,
  input  wire logic        full_acc,
  input  wire logic [15:0] word_in,
  output logic      [15:0] word_out,
  output logic             limited,
  output logic             size_hit
);
  logic ext_used;
  always_comb begin
    ext_used = (acc_in[35:31] != 5'h00) && (acc_in[35:31] != 5'h1F);
    limited  = full_acc && ext_used;
    if (limited) begin
      word_out = acc_in[35] ? `SAMU_SAT_NEG : `SAMU_SAT_POS;
    end else if (full_acc) begin
      word_out = acc_in[31:16];
    end else begin
      word_out = word_in;
    end
    size_hit = full_acc ? (acc_in[30] != acc_in[29]) : (word_in[14] != word_in[13]);
  end
endmodule

// *** include/samu_cfg.svh ***
// Constants for the short absolute move unit
`ifndef SAMU_CFG_SVH
`define SAMU_CFG_SVH
`define SAMU_ADDR_W      16
`define SAMU_SHORT_W     6
`define SAMU_WORD_W      16
`define SAMU_ACC_W       36
`define SAMU_CCR_L_BIT   6
`define SAMU_CCR_SZ_BIT  7
`define SAMU_SAT_POS     16'h7FFF
`define SAMU_SAT_NEG     16'h8000
`define SAMU_CYC_REG     2
`define SAMU_CYC_IMM     4
`define SAMU_REGS        11
`endif

// *** include/samu_pkg.sv ***
// Types for the short absolute move unit
package samu_pkg;
  typedef enum logic [1:0] {
    SAMU_LOAD,
    SAMU_STORE,
    SAMU_STORE_IMM
  } samu_form_t;

  typedef enum logic [3:0] {
    SAMU_R_A,
    SAMU_R_B,
    SAMU_R_A1,
    SAMU_R_B1,
    SAMU_R_X0,
    SAMU_R_Y0,
    SAMU_R_Y1,
    SAMU_R_R0,
    SAMU_R_R1,
    SAMU_R_R2,
    SAMU_R_R3,
    SAMU_R_N,
    SAMU_R_A0,
    SAMU_R_B0
  } samu_reg_t;

  typedef struct packed {
    samu_form_t  form;
    samu_reg_t   reg_sel;
    logic [5:0]  short_address_field;
    logic [15:0] imm;
  } samu_cmd_t;

  typedef struct packed {
    logic        we;
    samu_reg_t   reg_sel;
    logic [35:0] acc_val;
    logic [15:0] word_val;
  } samu_wb_t;
endpackage
